// ==== verif/lpc_core_model.sv ====
module lpc_core_model (
  input wire logic mclk_i,
  output logic sleep_instr_o,
  output logic irq_accept_o,
  output logic snooze_req_o,
  output logic snooze_end_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Core side of the sequencer
  // ----------------------------------------
  initial begin
    sleep_instr_o = 1'b0;
    irq_accept_o = 1'b0;
    snooze_req_o = 1'b0;
    snooze_end_o = 1'b0;
  end
  // Caller has written the standby control word first; the pulse is the instruction itself
  task automatic exec_sleep();
    @(posedge mclk_i);
    sleep_instr_o <= 1'b1;
    @(posedge mclk_i);
    sleep_instr_o <= 1'b0;
  endtask
  // One-cycle pulse, like an interrupt controller handing over one request
  task automatic accept_irq();
    @(posedge mclk_i);
    irq_accept_o <= 1'b1;
    @(posedge mclk_i);
    irq_accept_o <= 1'b0;
  endtask
  task automatic set_cond(input logic req, input logic fin);
    @(posedge mclk_i);
    snooze_req_o <= req;
    snooze_end_o <= fin;
  endtask
endmodule

// ==== verif/test_low_power_mode_controller.sv ====
module test_low_power_mode_controller;
  timeunit 1ns;
  timeprecision 1ns;
  import lpc_pkg::*;
  localparam logic [2:0] LV [4] = '{LPC_OPC_HIGH, LPC_OPC_MID1, LPC_OPC_LOW, LPC_OPC_MID2};
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic [31:0] module_run_o;
  logic [2:0] power_level_o;
  lpc_state_e state_o;
  logic pready_o, pslverr_o, sleep_instr_i, irq_accept_i, snooze_req_i, snooze_end_i, cpu_halt_o, irq_resume_o;
  logic core_tick_o, periph_tick_o, conv_tick_o, flash_tick_o, ram_access_o, flash_run_o, transfer_run_o;
  logic main_osc_en_o, fast_osc_en_o, pll_en_o, sub_osc_en_o, slow_osc_en_o;
  logic watchdog_run_o, detector_run_o, calendar_run_o, lptimer_run_o;
  int fails = 0;
  int compares = 0;
  wire [3:0] ticks = {flash_tick_o, conv_tick_o, periph_tick_o, core_tick_o};
  wire [4:0] osc = {slow_osc_en_o, sub_osc_en_o, pll_en_o, fast_osc_en_o, main_osc_en_o};
  wire [3:0] unit = {lptimer_run_o, calendar_run_o, detector_run_o, watchdog_run_o};
  wire [3:0] gates = {transfer_run_o, flash_run_o, ram_access_o, cpu_halt_o};
  always #5 mclk_i = ~mclk_i;
  lpc_ctrl u_lpc_ctrl (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .sleep_instr_i(sleep_instr_i), .irq_accept_i(irq_accept_i),
    .snooze_req_i(snooze_req_i), .snooze_end_i(snooze_end_i), .cpu_halt_o(cpu_halt_o),
    .irq_resume_o(irq_resume_o), .core_tick_o(core_tick_o), .periph_tick_o(periph_tick_o),
    .conv_tick_o(conv_tick_o), .flash_tick_o(flash_tick_o), .module_run_o(module_run_o),
    .ram_access_o(ram_access_o), .flash_run_o(flash_run_o), .transfer_run_o(transfer_run_o),
    .main_osc_en_o(main_osc_en_o), .fast_osc_en_o(fast_osc_en_o), .pll_en_o(pll_en_o),
    .sub_osc_en_o(sub_osc_en_o), .slow_osc_en_o(slow_osc_en_o), .watchdog_run_o(watchdog_run_o),
    .detector_run_o(detector_run_o), .calendar_run_o(calendar_run_o), .lptimer_run_o(lptimer_run_o),
    .power_level_o(power_level_o), .state_o(state_o));
  lpc_core_model u_core (.mclk_i(mclk_i), .sleep_instr_o(sleep_instr_i), .irq_accept_o(irq_accept_i),
    .snooze_req_o(snooze_req_i), .snooze_end_o(snooze_end_i));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) begin
      fails++;
      conclude();
    end
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask
  task automatic st(input lpc_state_e s);
    #1;
    chk(32'(state_o), 32'(s));
  endtask
  // Counts cycles between two ticks of one divider
  task automatic period(input int i, input int exp);
    int n;
    n = 0;
    while (ticks[i] !== 1'b1 && n < 40) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (ticks[i] !== 1'b1 && n < 40);
    chk(32'(n), 32'(exp));
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    logic [31:0] q;
    logic e;
    logic seen;
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(LPC_MSTP_OFS, LPC_MSTP_RST);
    rd(LPC_OSC_OFS, 32'(LPC_OSC_RST));
    rd(LPC_UNIT_OFS, 32'(LPC_UNIT_RST));
    rd(LPC_DIV_OFS, LPC_DIV_RST);
    rd(LPC_OPC_OFS, 32'(LPC_OPC_RST));
    chk(module_run_o, 32'h0000_0000);
    apb(1'b1, 8'h20, 32'hffff_ffff, q, e);
    chk(32'(e), 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0000_0000, q, e);
    chk(q, LPC_ERR_DATA);
    chk(32'(e), 32'h0000_0001);
    wr(LPC_MSTP_OFS, 32'h7fff_fffe);
    repeat (2) @(posedge mclk_i);
    chk(module_run_o, 32'h8000_0001);
    wr(LPC_DIV_OFS, 32'h0000_4321);
    for (int i = 0; i < 4; i++) period(i, i + 2);
    foreach (LV[i]) begin
      wr(LPC_OPC_OFS, 32'(LV[i]));
      rd(LPC_OPC_OFS, 32'(LV[i]));
      chk(32'(power_level_o), 32'(LV[i]));
    end
    wr(LPC_OPC_OFS, 32'h0000_0003);
    chk(32'(power_level_o), 32'(LPC_OPC_MID2));
    wr(LPC_SBY_OFS, 32'h0000_0000);
    repeat (3) @(posedge mclk_i);
    st(LPC_RUN);
    for (int m = 0; m < 2; m++) begin
      wr(LPC_SBY_OFS, 32'(m));
      u_core.exec_sleep();
      st(m ? LPC_DSLEEP : LPC_SLEEP);
      chk(32'(gates), m ? 32'h0000_0001 : 32'h0000_000f);
      chk(module_run_o, 32'h8000_0001);
      chk(32'({power_level_o, unit}), 32'({LPC_OPC_MID2, 4'hf}));
      u_core.exec_sleep();
      st(m ? LPC_DSLEEP : LPC_SLEEP);
      u_core.accept_irq();
      st(LPC_RUN);
      chk(32'({irq_resume_o, cpu_halt_o}), 32'h0000_0002);
    end
    wr(LPC_UNIT_OFS, 32'h0000_0005);
    wr(LPC_SNZ_OFS, 32'h0000_0000);
    wr(LPC_SBY_OFS, 32'h0000_0002);
    u_core.exec_sleep();
    u_core.set_cond(1'b1, 1'b0);
    seen = 1'b0;
    repeat (12) begin
      @(posedge mclk_i);
      #1;
      seen = seen | (|ticks);
    end
    st(LPC_STANDBY);
    chk(32'({seen, osc, unit, gates}), 32'({1'b0, 5'h18, 4'h5, 4'h1}));
    chk(module_run_o, 32'h0000_0000);
    u_core.accept_irq();
    st(LPC_RUN);
    u_core.set_cond(1'b0, 1'b0);
    wr(LPC_SNZ_OFS, 32'h0000_0003);
    u_core.exec_sleep();
    u_core.set_cond(1'b1, 1'b0);
    repeat (2) @(posedge mclk_i);
    st(LPC_SNOOZE);
    chk(32'({osc, gates, power_level_o}), 32'({5'h1f, 4'hb, LPC_OPC_MID2}));
    u_core.set_cond(1'b0, 1'b1);
    repeat (2) @(posedge mclk_i);
    st(LPC_STANDBY);
    u_core.set_cond(1'b1, 1'b0);
    repeat (2) @(posedge mclk_i);
    st(LPC_SNOOZE);
    // Interrupt and end condition arrive in the same cycle: the interrupt must win
    fork
      u_core.set_cond(1'b1, 1'b1);
      u_core.accept_irq();
    join
    st(LPC_RUN);
    chk(32'(irq_resume_o), 32'h0000_0001);
    u_core.set_cond(1'b0, 1'b0);
    rd(LPC_MSTP_OFS, 32'h7fff_fffe);
    rd(LPC_DIV_OFS, 32'h0000_4321);
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(LPC_MSTP_OFS, LPC_MSTP_RST);
    st(LPC_RUN);
    conclude();
  end
endmodule

// ==== verilog/lpc_clk_div.sv ====
// Clock enable generator: pulses once every (ratio+1) cycles while running.
module lpc_clk_div #(
  parameter int W = 4
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic [W-1:0] ratio_i,
  output logic tick_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      // Halted clocks keep their phase so divided domains restart cleanly
      tick_o <= 1'b0;
    end else if (cnt_q >= ratio_i) begin
      cnt_q <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ==== verilog/lpc_ctrl.sv ====
// ----------------------------------------
// Summary of operation
// - Four independent divide ratios: core, peripheral, converter, flash interface clocks.
// - Per-module stop bits gate each peripheral alone.
// - Four low power states: sleep, deep sleep, standby, snooze.
// - Four power levels: high, middle 1, middle 2, low speed.
// - Selected power level stays in force in run, sleep, deep sleep, snooze.
// - Software writes control then sleep instruction; only instruction changes state.
// - Reset or accepted interrupt ends sleep, deep sleep, standby; handler resumes.
// - Snooze entered only from standby when snooze conditions hold.
// - Snooze ends on interrupt, end condition, or reset.
// - Interrupt exit resumes CPU handler; end condition returns to standby.
// - Main RAM retained always; accessible in sleep/snooze, halted in deep sleep/standby.
// - Voltage detector, calendar, low power timer may run in every low state.
// - Independent watchdog and its oscillator may run in every low state.
// - Such units follow their own enable setting, not the state.
// - Halted retained units suspend operation but keep register contents.
// ----------------------------------------
//
// Chosen here: the APB register port and the placing of the registers.
module lpc_ctrl #(
  parameter int NMOD = lpc_pkg::LPC_NMOD
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_instr_i,
  input wire logic irq_accept_i,
  input wire logic snooze_req_i,
  input wire logic snooze_end_i,
  output logic cpu_halt_o,
  output logic irq_resume_o,
  output logic core_tick_o,
  output logic periph_tick_o,
  output logic conv_tick_o,
  output logic flash_tick_o,
  output logic [NMOD-1:0] module_run_o,
  output logic ram_access_o,
  output logic flash_run_o,
  output logic transfer_run_o,
  output logic main_osc_en_o,
  output logic fast_osc_en_o,
  output logic pll_en_o,
  output logic sub_osc_en_o,
  output logic slow_osc_en_o,
  output logic watchdog_run_o,
  output logic detector_run_o,
  output logic calendar_run_o,
  output logic lptimer_run_o,
  output logic [2:0] power_level_o,
  output lpc_pkg::lpc_state_e state_o
);
  import lpc_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] div_q;
  logic [NMOD-1:0] mstp_q;
  logic [1:0] sby_q;
  logic [2:0] opc_q;
  logic [1:0] snz_q;
  logic [4:0] osc_q;
  logic [3:0] unit_q;
  lpc_state_e state_q;
  lpc_state_e state_d;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic opc_ok;
  logic run_clk;

  // Single-cycle access phase: pready is always high
  assign pready_o = 1'b1;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign addr_ok = paddr_i inside {LPC_DIV_OFS, LPC_MSTP_OFS, LPC_SBY_OFS, LPC_OPC_OFS,
                                   LPC_SNZ_OFS, LPC_STAT_OFS, LPC_OSC_OFS, LPC_UNIT_OFS};
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign opc_ok = pwdata_i[2:0] inside {LPC_OPC_HIGH, LPC_OPC_MID1, LPC_OPC_MID2, LPC_OPC_LOW};

  // Register writes take effect only at the access edge
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= LPC_DIV_RST;
      mstp_q <= LPC_MSTP_RST[NMOD-1:0];
      sby_q <= '0;
      opc_q <= LPC_OPC_RST;
      snz_q <= '0;
      osc_q <= LPC_OSC_RST;
      unit_q <= LPC_UNIT_RST;
    end else if (wr_en) begin
      case (paddr_i)
        LPC_DIV_OFS: div_q <= pwdata_i;
        LPC_MSTP_OFS: mstp_q <= pwdata_i[NMOD-1:0];
        LPC_SBY_OFS: sby_q <= pwdata_i[1:0];
        LPC_OPC_OFS: begin
          // Prohibited codes are ignored so the level stays legal
          if (opc_ok) begin
            opc_q <= pwdata_i[2:0];
          end
        end
        LPC_SNZ_OFS: snz_q <= pwdata_i[1:0];
        LPC_OSC_OFS: osc_q <= pwdata_i[4:0];
        LPC_UNIT_OFS: unit_q <= pwdata_i[3:0];
        default: ;
      endcase
    end
  end

  // Read data registered; unmapped reads return zero with an error
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_o <= LPC_ERR_DATA;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        LPC_DIV_OFS: prdata_o <= div_q;
        LPC_MSTP_OFS: prdata_o <= 32'(mstp_q);
        LPC_SBY_OFS: prdata_o <= 32'(sby_q);
        LPC_OPC_OFS: prdata_o <= 32'(opc_q);
        LPC_SNZ_OFS: prdata_o <= 32'(snz_q);
        LPC_STAT_OFS: prdata_o <= 32'(state_q);
        LPC_OSC_OFS: prdata_o <= 32'(osc_q);
        LPC_UNIT_OFS: prdata_o <= 32'(unit_q);
        default: prdata_o <= LPC_ERR_DATA;
      endcase
    end
  end

  // ----------------------------------------
  // Power state sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      LPC_RUN: begin
        // Only the sleep instruction moves the state
        if (sleep_instr_i) begin
          if (sby_q[LPC_SBY_BIT]) begin
            state_d = LPC_STANDBY;
          end else if (sby_q[LPC_DSLP_BIT]) begin
            state_d = LPC_DSLEEP;
          end else begin
            state_d = LPC_SLEEP;
          end
        end
      end
      LPC_SLEEP, LPC_DSLEEP: begin
        if (irq_accept_i) begin
          state_d = LPC_RUN;
        end
      end
      LPC_STANDBY: begin
        if (irq_accept_i) begin
          state_d = LPC_RUN;
        end else if (snz_q[LPC_SNZE_BIT] && snooze_req_i) begin
          state_d = LPC_SNOOZE;
        end
      end
      LPC_SNOOZE: begin
        // Interrupt has priority over an end condition in the same cycle
        if (irq_accept_i) begin
          state_d = LPC_RUN;
        end else if (snz_q[LPC_SNZEND_BIT] && snooze_end_i) begin
          state_d = LPC_STANDBY;
        end
      end
      default: state_d = LPC_RUN;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= LPC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Resume pulse marks handler entry after an interrupt wake-up
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_resume_o <= 1'b0;
    end else begin
      irq_resume_o <= (state_q != LPC_RUN) && (state_d == LPC_RUN);
    end
  end

  // ----------------------------------------
  // Unit gating from state
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_halt_o <= 1'b0;
      ram_access_o <= 1'b1;
      flash_run_o <= 1'b1;
      transfer_run_o <= 1'b1;
      main_osc_en_o <= 1'b1;
      fast_osc_en_o <= 1'b1;
      pll_en_o <= 1'b1;
      module_run_o <= '0;
    end else begin
      // CPU halt keeps its state: only its clock is withheld
      cpu_halt_o <= (state_d != LPC_RUN);
      ram_access_o <= state_d inside {LPC_RUN, LPC_SLEEP, LPC_SNOOZE};
      flash_run_o <= state_d inside {LPC_RUN, LPC_SLEEP};
      transfer_run_o <= state_d inside {LPC_RUN, LPC_SLEEP, LPC_SNOOZE};
      main_osc_en_o <= osc_q[LPC_OSC_MAIN] && (state_d != LPC_STANDBY);
      fast_osc_en_o <= osc_q[LPC_OSC_FAST] && (state_d != LPC_STANDBY);
      pll_en_o <= osc_q[LPC_OSC_PLL] && (state_d != LPC_STANDBY);
      // Standby halts every peripheral with retention
      module_run_o <= (state_d == LPC_STANDBY) ? '0 : ~mstp_q;
    end
  end

  // Always-on units follow only their own enables
  assign sub_osc_en_o = osc_q[LPC_OSC_SUB];
  assign slow_osc_en_o = osc_q[LPC_OSC_SLOW];
  assign watchdog_run_o = unit_q[LPC_UNIT_WDOG];
  assign detector_run_o = unit_q[LPC_UNIT_VDET];
  assign calendar_run_o = unit_q[LPC_UNIT_CAL];
  assign lptimer_run_o = unit_q[LPC_UNIT_TIMER];
  assign power_level_o = opc_q;
  assign state_o = state_q;
  assign run_clk = (state_q != LPC_STANDBY);

  // ----------------------------------------
  // Divided clock enables
  // ----------------------------------------
  logic [LPC_NDIV-1:0] ticks;
  for (genvar g = 0; g < LPC_NDIV; g++) begin : g_div
    lpc_clk_div #(.W(LPC_DIV_W)) u_div (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .run_i(run_clk),
      .ratio_i(div_q[g*LPC_DIV_W +: LPC_DIV_W]),
      .tick_o(ticks[g])
    );
  end
  assign core_tick_o = ticks[0];
  assign periph_tick_o = ticks[1];
  assign conv_tick_o = ticks[2];
  assign flash_tick_o = ticks[3];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sleep_entry_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_q == LPC_RUN && !sleep_instr_i) |=> state_q == LPC_RUN)
    else $error("state left run without sleep instruction");
  irq_wake_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_q inside {LPC_SLEEP, LPC_DSLEEP, LPC_STANDBY} && irq_accept_i) |=> state_q == LPC_RUN && irq_resume_o)
    else $error("interrupt did not wake the core");
  snooze_src_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_q == LPC_SNOOZE && $past(state_q) != LPC_SNOOZE) |-> $past(state_q) == LPC_STANDBY)
    else $error("snooze entered from wrong state");
  snooze_end_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_q == LPC_SNOOZE && !irq_accept_i && snooze_end_i && snz_q[LPC_SNZEND_BIT]) |=> state_q == LPC_STANDBY)
    else $error("snooze end did not return to standby");
  ram_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    ##1 ram_access_o == ($past(state_d) inside {LPC_RUN, LPC_SLEEP, LPC_SNOOZE}))
    else $error("ram access wrong for state");
  osc_stop_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_q == LPC_STANDBY && $past(state_q) == LPC_STANDBY) |-> !main_osc_en_o && !fast_osc_en_o && !pll_en_o)
    else $error("fast oscillators running in standby");
  deep_halt_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_q == LPC_DSLEEP && $past(state_q) == LPC_DSLEEP) |-> !flash_run_o && !transfer_run_o && cpu_halt_o)
    else $error("deep sleep left flash or transfer running");
  level_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !(wr_en && paddr_i == LPC_OPC_OFS) |=> $stable(power_level_o))
    else $error("power level changed without a write");
  mstp_gate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_q == LPC_RUN && state_d == LPC_RUN) |=> module_run_o == ~$past(mstp_q))
    else $error("module run does not follow stop bits");
  snooze_irq_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_q == LPC_SNOOZE && irq_accept_i) |=> state_q == LPC_RUN && irq_resume_o)
    else $error("interrupt did not end snooze");
  standby_entry_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (state_q == LPC_RUN && sleep_instr_i && sby_q[LPC_SBY_BIT]) |=> state_q == LPC_STANDBY)
    else $error("sleep instruction did not enter standby");
  // Gating outputs are registered from the next state, so they track the state one for one
  cpu_halt_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    cpu_halt_o == (state_q != LPC_RUN))
    else $error("cpu halt does not match state");
  standby_mod_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    state_q == LPC_STANDBY |-> module_run_o == '0)
    else $error("peripheral running in standby");
  snooze_run_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    state_q == LPC_SNOOZE |-> transfer_run_o && ram_access_o && cpu_halt_o)
    else $error("snooze gating wrong");
  unit_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !(wr_en && paddr_i == LPC_UNIT_OFS) |=> $stable({watchdog_run_o, detector_run_o, calendar_run_o, lptimer_run_o}))
    else $error("always-on unit changed without a write");
  osc_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !(wr_en && paddr_i == LPC_OSC_OFS) |=> $stable({sub_osc_en_o, slow_osc_en_o}))
    else $error("slow oscillator changed without a write");
endmodule

// ==== verilog/lpc_pkg.sv ====
package lpc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] LPC_DIV_OFS = 8'h00;
  localparam logic [7:0] LPC_MSTP_OFS = 8'h04;
  localparam logic [7:0] LPC_SBY_OFS = 8'h08;
  localparam logic [7:0] LPC_OPC_OFS = 8'h0c;
  localparam logic [7:0] LPC_SNZ_OFS = 8'h10;
  localparam logic [7:0] LPC_STAT_OFS = 8'h14;
  localparam logic [7:0] LPC_OSC_OFS = 8'h18;
  localparam logic [7:0] LPC_UNIT_OFS = 8'h1c;
  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int LPC_DIV_W = 4;
  localparam int LPC_NDIV = 4;
  localparam int LPC_NMOD = 32;
  localparam logic [31:0] LPC_MSTP_RST = 32'hffff_ffff;
  localparam logic [31:0] LPC_DIV_RST = 32'h0000_0000;
  localparam logic [2:0] LPC_OPC_RST = 3'h0;
  localparam logic [4:0] LPC_OSC_RST = 5'h1f;
  localparam logic [3:0] LPC_UNIT_RST = 4'hf;
  localparam int LPC_SBY_BIT = 1;
  localparam int LPC_DSLP_BIT = 0;
  localparam int LPC_SNZE_BIT = 0;
  localparam int LPC_SNZEND_BIT = 1;
  // Oscillator enable bit positions
  localparam int LPC_OSC_MAIN = 0;
  localparam int LPC_OSC_FAST = 1;
  localparam int LPC_OSC_PLL = 2;
  localparam int LPC_OSC_SUB = 3;
  localparam int LPC_OSC_SLOW = 4;
  // Always-on unit enable bit positions
  localparam int LPC_UNIT_WDOG = 0;
  localparam int LPC_UNIT_VDET = 1;
  localparam int LPC_UNIT_CAL = 2;
  localparam int LPC_UNIT_TIMER = 3;
  // Operating power levels
  localparam logic [2:0] LPC_OPC_HIGH = 3'h0;
  localparam logic [2:0] LPC_OPC_MID1 = 3'h2;
  localparam logic [2:0] LPC_OPC_MID2 = 3'h4;
  localparam logic [2:0] LPC_OPC_LOW = 3'h6;
  localparam logic [31:0] LPC_ERR_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    LPC_RUN,
    LPC_SLEEP,
    LPC_DSLEEP,
    LPC_STANDBY,
    LPC_SNOOZE
  } lpc_state_e;
endpackage
